// ===== hw/mmc_params.svh
// Constants for the matched-memory cycle controller.
`ifndef MMC_PARAMS_SVH
`define MMC_PARAMS_SVH
`define MMC_CLK_PERIOD_PS 10000
`define MMC_PROC_CLK_PS 62500
`define MMC_PROC_CLK_CYC ((`MMC_PROC_CLK_PS + `MMC_CLK_PERIOD_PS - 1) / `MMC_CLK_PERIOD_PS)
`define MMC_FAST_MIN_CLKS 3
`define MMC_DEFAULT_MIN_CLKS 4
`define MMC_CNT_W 4
`endif

// ===== hw/mmc_pkg.sv
// Types shared by the matched-memory cycle controller.
package mmc_pkg;
  typedef enum logic [2:0] {
    MMC_IDLE,
    MMC_STATUS,
    MMC_COMMAND,
    MMC_DEFAULT_CMD,
    MMC_END
  } mmc_state_e;
  typedef struct packed {
    logic proc_cycle;
    logic memory_io;
    logic status_active;
  } mmc_req_s;
  typedef struct packed {
    logic fast_cycle_capable_n;
    logic address_latch_strobe_n;
    logic command_strobe_n;
    logic fast_command_n;
  } mmc_bus_s;
endpackage : mmc_pkg

// ===== hw/mmc_tick.sv
// Divider that marks the end of each processor clock state.
`timescale 1ns/1ps
`include "mmc_params.svh"
module mmc_tick #(
  parameter int unsigned DIV = `MMC_PROC_CLK_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic restart_i,
  output logic tick_o
);
  typedef struct packed {
    logic [7:0] cnt;
  } mmc_tick_st_s;
  mmc_tick_st_s st;
  mmc_tick_st_s next_st;
  localparam logic [7:0] LAST = 8'(DIV - 1);
  always_comb begin
    next_st = st;
    if (restart_i || st.cnt == LAST) begin
      next_st.cnt = 8'h00;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign tick_o = (st.cnt == LAST) && !restart_i;
endmodule : mmc_tick

// ===== hw/mmc_ctrl.sv
// Matched-memory cycle controller on the system-board side.
`timescale 1ns/1ps
`include "mmc_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Assert fast-cycle-capable line whenever the processor is the master.
// - Ignore requests from 8-bit slaves or outside processor cycles.
// - Keep address latch and normal command inactive during fast cycles.
// - Only the processor masters fast cycles; others get ordinary cycles.
// - OR all connector request inputs into one request.
// - Fast command strobe only in processor cycles; its end ends cycle.
// - Fast cycles only with 16- or 32-bit slaves.
// - Fast cycle at least 3 clocks, default cycle at least 4 clocks.
// - Address, byte enables and definition valid in the first clock.
// - Either status bit starts the cycle; status state then command state.
// - Repeat command state while channel ready is inactive.
// - Returned request gives fast command; otherwise default cycle.
// - Cycle type chosen fresh each cycle with no carried state.
// - Extend the cycle until channel ready is sampled active.
module mmc_ctrl #(
  parameter int unsigned CONNECTORS = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Processor side
  input wire logic [1:0] status_n_i,
  input wire logic proc_master_i,
  input wire logic memory_io_i,
  output logic cycle_done_o,
  output logic fast_done_o,
  // Channel side
  input wire logic [CONNECTORS-1:0] fast_cycle_request_n_i,
  input wire logic slave_width_indicator_n_i,
  input wire logic channel_ready_i,
  output mmc_pkg::mmc_bus_s bus_o
);
  typedef struct packed {
    mmc_pkg::mmc_state_e state;
    logic fast;
    logic [`MMC_CNT_W-1:0] clks;
    logic latch_seen;
    logic [7:0] span;
  } mmc_st_s;
  mmc_st_s st;
  mmc_st_s next_st;
  logic tick;
  logic start;
  logic request;
  logic done;
  localparam int CNT_W = `MMC_CNT_W;
  localparam logic [`MMC_CNT_W-1:0] FAST_MIN = CNT_W'(`MMC_FAST_MIN_CLKS);
  localparam logic [`MMC_CNT_W-1:0] DEF_MIN = CNT_W'(`MMC_DEFAULT_MIN_CLKS);
  // Shortest legal spans in system clocks, counted from the edge that starts a cycle.
  localparam logic [7:0] FAST_SPAN = 8'(`MMC_FAST_MIN_CLKS * `MMC_PROC_CLK_CYC - 1);
  localparam logic [7:0] DEF_SPAN = 8'(`MMC_DEFAULT_MIN_CLKS * `MMC_PROC_CLK_CYC - 1);
  ////////////////////////////////////////////////////////////////////////////////
  assign start = (st.state == mmc_pkg::MMC_IDLE) && (status_n_i != 2'b11);
  assign request = !(&fast_cycle_request_n_i);
  logic fast_pick;
  // Once the latch strobe has gone out in this status state the cycle stays a default one,
  // so a late request can never pull the latch strobe into a fast cycle.
  assign fast_pick = request && proc_master_i && !slave_width_indicator_n_i
    && !st.latch_seen;
  // Processor timing restarts on each status so the state grid aligns with the cycle.
  mmc_tick #(
    .DIV(`MMC_PROC_CLK_CYC)
  ) u_tick (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .restart_i(start),
    .tick_o(tick)
  );
  always_comb begin
    next_st = st;
    done = 1'b0;
    // The span counter only feeds the length checks, so it simply saturates when idle.
    if (st.span != 8'hff) begin
      next_st.span = st.span + 8'h01;
    end
    unique case (st.state)
      mmc_pkg::MMC_IDLE: begin
        if (start) begin
          next_st.state = mmc_pkg::MMC_STATUS;
          next_st.clks = '0;
          next_st.fast = 1'b0;
          next_st.latch_seen = 1'b0;
          next_st.span = 8'h00;
        end
      end
      mmc_pkg::MMC_STATUS: begin
        if (!fast_pick) begin
          next_st.latch_seen = 1'b1;
        end
        if (tick) begin
          next_st.clks = st.clks + 1'b1;
          // Narrow slaves and other masters fall back to the default cycle.
          next_st.fast = fast_pick;
          next_st.state = (next_st.fast) ? mmc_pkg::MMC_COMMAND : mmc_pkg::MMC_DEFAULT_CMD;
        end
      end
      mmc_pkg::MMC_COMMAND, mmc_pkg::MMC_DEFAULT_CMD: begin
        if (tick) begin
          if (st.clks != 4'hf) begin
            next_st.clks = st.clks + 1'b1;
          end
          // Ready is only looked at on the processor state boundary.
          // The wait count saturates, so the test avoids an increment that could wrap to zero.
          if (channel_ready_i &&
              st.clks >= (st.fast ? FAST_MIN - 4'h2 : DEF_MIN - 4'h2)) begin
            next_st.state = mmc_pkg::MMC_END;
          end
        end
      end
      mmc_pkg::MMC_END: begin
        if (tick) begin
          done = 1'b1;
          next_st.state = mmc_pkg::MMC_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{state: mmc_pkg::MMC_IDLE, fast: 1'b0, clks: '0, latch_seen: 1'b0, span: 8'h00};
    end else begin
      st <= next_st;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  logic in_cmd;
  assign in_cmd = (st.state == mmc_pkg::MMC_COMMAND) || (st.state == mmc_pkg::MMC_DEFAULT_CMD);
  assign bus_o.fast_cycle_capable_n = !proc_master_i;
  assign bus_o.fast_command_n = !(in_cmd && st.fast && proc_master_i);
  assign bus_o.address_latch_strobe_n =
    !(st.state == mmc_pkg::MMC_STATUS && !fast_pick);
  assign bus_o.command_strobe_n = !(in_cmd && !st.fast);
  assign cycle_done_o = done;
  assign fast_done_o = done && st.fast;
  ////////////////////////////////////////////////////////////////////////////////
  // Strobe checks, checks on the choice of cycle and length checks follow, mixed in no fixed order.
  a_fast_no_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !bus_o.fast_command_n |-> bus_o.command_strobe_n && bus_o.address_latch_strobe_n)
    else $error("Normal strobes active during fast cycle.");
  a_fast_no_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !bus_o.fast_command_n |-> !st.latch_seen)
    else $error("Latch strobe went out earlier in a fast cycle.");
  a_fast_only_proc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !bus_o.fast_command_n |-> proc_master_i)
    else $error("Fast command without processor master.");
  a_other_master: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == mmc_pkg::MMC_STATUS && tick && !proc_master_i) |=> !st.fast)
    else $error("Other master got a fast cycle.");
  a_capable_line: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    proc_master_i |-> !bus_o.fast_cycle_capable_n)
    else $error("Capable line not asserted.");
  a_capable_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !proc_master_i |-> bus_o.fast_cycle_capable_n)
    else $error("Capable line asserted for another master.");
  a_narrow_default: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == mmc_pkg::MMC_STATUS && tick && slave_width_indicator_n_i)
      |=> !st.fast)
    else $error("Narrow slave got fast cycle.");
  a_narrow_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == mmc_pkg::MMC_STATUS && slave_width_indicator_n_i)
      |-> !bus_o.address_latch_strobe_n)
    else $error("Narrow slave cycle without latch strobe.");
  a_wait_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (in_cmd && tick && !channel_ready_i) |=> in_cmd)
    else $error("Cycle ended while not ready.");
  a_hold_off_tick: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (in_cmd && !tick) |=> in_cmd)
    else $error("Command state left between processor clocks.");
  a_fast_ready_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == mmc_pkg::MMC_COMMAND && tick && channel_ready_i)
      |=> st.state == mmc_pkg::MMC_END)
    else $error("Fast cycle not finished on ready.");
  a_default_ready_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == mmc_pkg::MMC_DEFAULT_CMD && tick && channel_ready_i
      && st.clks >= DEF_MIN - 4'h2) |=> st.state == mmc_pkg::MMC_END)
    else $error("Default cycle not finished on ready.");
  a_or_request: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == mmc_pkg::MMC_STATUS && tick && !(&fast_cycle_request_n_i) && !st.latch_seen
      && proc_master_i && !slave_width_indicator_n_i) |=> st.fast)
    else $error("Request from one connector not honoured.");
  a_request_needed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == mmc_pkg::MMC_STATUS && tick && !request) |=> !st.fast)
    else $error("Fast cycle without a request.");
  a_default_pick: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == mmc_pkg::MMC_STATUS && tick && !fast_pick)
      |=> st.state == mmc_pkg::MMC_DEFAULT_CMD)
    else $error("Default cycle not entered.");
  a_default_strobe: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st.state == mmc_pkg::MMC_DEFAULT_CMD |-> !bus_o.command_strobe_n && bus_o.fast_command_n)
    else $error("Wrong strobe in default command state.");
  a_fast_strobe: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.state == mmc_pkg::MMC_COMMAND && proc_master_i) |-> !bus_o.fast_command_n)
    else $error("Fast command strobe missing in fast command state.");
  a_end_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st.state == mmc_pkg::MMC_END |-> bus_o.fast_command_n && bus_o.command_strobe_n)
    else $error("Command strobe still active at cycle end.");
  a_status_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start |=> st.state == mmc_pkg::MMC_STATUS)
    else $error("Status state did not follow start.");
  a_status_span: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start |=> (st.state == mmc_pkg::MMC_STATUS) [*7])
    else $error("Status state shorter than one processor clock.");
  a_fresh_choice: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start |=> !st.fast && !st.latch_seen)
    else $error("Cycle choice carried over from the last cycle.");
  a_fast_min_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fast_done_o |-> st.clks >= FAST_MIN - 1'b1)
    else $error("Fast cycle too short.");
  a_fast_span: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fast_done_o |-> st.span >= FAST_SPAN)
    else $error("Fast cycle shorter than its minimum span.");
  a_default_span: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cycle_done_o && !st.fast) |-> st.span >= DEF_SPAN)
    else $error("Default cycle shorter than its minimum span.");
  a_done_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cycle_done_o |=> st.state == mmc_pkg::MMC_IDLE && !cycle_done_o)
    else $error("Cycle end pulse longer than one clock.");
endmodule : mmc_ctrl

// ===== test/mmc_slave_model.sv
// Channel slave model that answers the matched-memory handshake.
`timescale 1ns/1ps
module mmc_slave_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Board side
  input wire mmc_pkg::mmc_bus_s bus_i,
  // Scenario control
  input wire logic want_i,
  input wire logic wide_i,
  input wire logic [1:0] slot_i,
  input wire logic [7:0] hold_i,
  // Channel side
  output logic [2:0] request_n_o,
  output logic width_n_o,
  output logic ready_o
);
  logic [7:0] cnt;
  // The request comes from the decode alone, so it stays valid for the whole cycle.
  always_comb begin
    request_n_o = 3'h7;
    if (want_i) begin
      request_n_o[slot_i] = 1'b0;
    end
  end
  assign width_n_o = !wide_i;
  // No data path at these ports, so the transfer itself is not modelled.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 8'h00;
    end else if (bus_i.fast_command_n && bus_i.command_strobe_n) begin
      cnt <= 8'h00;
    end else if (cnt != 8'hff) begin
      cnt <= cnt + 8'h01;
    end
  end
  assign ready_o = (cnt >= hold_i);
endmodule : mmc_slave_model

// ===== test/matched_memory_cycle_control_bench.sv
// Self-checking bench for the matched-memory cycle controller.
`timescale 1ns/1ps
module matched_memory_cycle_control_bench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] status_n_i = 2'h3;
  logic proc_master_i = 1'b1;
  logic memory_io_i = 1'b1;
  logic want = 1'b0;
  logic wide = 1'b1;
  logic [1:0] slot = 2'h0;
  logic [7:0] hold = 8'h00;
  logic [2:0] req_n;
  logic width_n;
  logic ready;
  logic cycle_done_o;
  logic fast_done_o;
  mmc_pkg::mmc_bus_s bus_o;
  int fails = 0;
  int checks = 0;
  int ticks = 0;
  int n;
  logic [3:0] sn;
  always #5 clk_i = ~clk_i;
  mmc_ctrl dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .status_n_i(status_n_i),
    .proc_master_i(proc_master_i), .memory_io_i(memory_io_i), .cycle_done_o(cycle_done_o),
    .fast_done_o(fast_done_o), .fast_cycle_request_n_i(req_n),
    .slave_width_indicator_n_i(width_n), .channel_ready_i(ready), .bus_o(bus_o));
  mmc_slave_model slave_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_o), .want_i(want),
    .wide_i(wide), .slot_i(slot), .hold_i(hold), .request_n_o(req_n), .width_n_o(width_n),
    .ready_o(ready));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // Runs one cycle; sn gathers fast strobe, latch strobe, command strobe, fast done.
  task automatic cyc(input logic m, input logic w, input logic wd, input logic [1:0] s,
    input logic [7:0] h);
    @(negedge clk_i);
    {proc_master_i, want, wide, slot, hold} = {m, w, wd, s, h};
    status_n_i = s[0] ? 2'h1 : 2'h2;
    n = 0;
    sn = 4'h0;
    do begin
      @(negedge clk_i);
      status_n_i = 2'h3;
      n++;
      sn |= {!bus_o.fast_command_n, !bus_o.address_latch_strobe_n, !bus_o.command_strobe_n,
        fast_done_o};
    end while (cycle_done_o !== 1'b1 && n < 400);
    chk(cycle_done_o, 1'b1);
    chk(bus_o.fast_cycle_capable_n, !m);
  endtask : cyc
  task t_fast;
    for (int s = 0; s < 3; s++) begin
      cyc(1'b1, 1'b1, 1'b1, 2'(s), 8'h00);
      chk(sn, 4'h9);
      chk(n >= 21, 1);
    end
    $display("fast cycles done");
  endtask : t_fast
  task t_mixed;
    cyc(1'b1, 1'b0, 1'b1, 2'h1, 8'h00);
    chk(sn, 4'h6);
    chk(n >= 28, 1);
    cyc(1'b1, 1'b1, 1'b0, 2'h0, 8'h00);
    chk(sn, 4'h6);
    cyc(1'b0, 1'b1, 1'b1, 2'h2, 8'h00);
    chk(sn, 4'h6);
    $display("default cycles done");
  endtask : t_mixed
  task t_wait;
    cyc(1'b1, 1'b1, 1'b1, 2'h2, 8'd30);
    chk(sn, 4'h9);
    chk(n >= 44, 1);
    cyc(1'b1, 1'b0, 1'b1, 2'h0, 8'd30);
    chk(n >= 44, 1);
    cyc(1'b1, 1'b1, 1'b1, 2'h1, 8'h78);
    chk(sn, 4'h9);
    chk(n >= 120, 1);
    $display("wait cycles done");
  endtask : t_wait
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 20000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk(bus_o, 4'h7);
    t_fast();
    t_mixed();
    t_wait();
    end_sim();
  end
endmodule : matched_memory_cycle_control_bench
